// ==== core/conv_out_pkg.sv ====
// constants for the converter output and mode pin block
// assumes a single 40 MHz convert clock, mclk, and synchronous pin levels
// What this block does
// RULE1: coding select high gives twos complement output
// RULE2: output enable low drives pins, high floats
// RULE3: duty select high enables the stabilizer
// RULE4: standard powerdown high stops normal operation
// RULE5: quasi powerdown high enters quasi powerdown; the code enters it only while standard powerdown is low
// RULE6: each result is one 12-bit word, msb 11
// RULE7: word appears five clocks after sampling edge
// RULE8: stabilizer accepts 35 to 65 percent duty; the code only passes duty_select through and never measures duty
// RULE9: over range flag travels with its word
package conv_out_pkg;
  localparam int          SAMPLE_W      = 12;
  localparam int          LATENCY_CYC   = 5;
  localparam int          DUTY_MIN_PCT  = 35;
  localparam int          DUTY_MAX_PCT  = 65;
  localparam int          DUTY_OUT_PCT  = 50;
  localparam int          CLK_PERIOD_NS = 25;
  localparam logic [11:0] SAMPLE_RST    = 12'h000;
  localparam logic [11:0] MSB_MASK      = 12'h800;
endpackage : conv_out_pkg

// ==== core/conv_out.sv ====
// converter output stage: latency pipe, coding, buffer, tri-state pins and mode pins
// assumes raw offset binary samples arrive on each mclk edge from the quantizer
`timescale 1ns/1ps
module conv_out #(
  parameter int SAMPLE_BITS = conv_out_pkg::SAMPLE_W,
  parameter int LATENCY     = conv_out_pkg::LATENCY_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic [SAMPLE_BITS-1:0] raw_sample,
  input  wire logic                   raw_over,
  input  wire logic                   coding_select,
  input  wire logic                   output_enable_n,
  input  wire logic                   duty_select,
  input  wire logic                   standard_powerdown,
  input  wire logic                   quasi_powerdown,
  input  wire logic                   sink_ready,
  output logic      [SAMPLE_BITS-1:0] sample_out,
  output logic      [SAMPLE_BITS-1:0] sample_oe,
  output logic                        over_range_flag,
  output logic                        over_range_oe,
  output logic                        sample_valid,
  output logic                        duty_cycle_stabilizer,
  output logic                        active,
  output logic                        quasi_down
);
  import conv_out_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // latency pipe: word plus flag, shifts while running
  logic [SAMPLE_BITS:0] pipe_r   [LATENCY];
  logic [SAMPLE_BITS:0] pipe_nxt [LATENCY];
  logic [LATENCY-1:0]   pv_r, pv_nxt;
  logic                 run;

  assign run = !standard_powerdown && !quasi_powerdown; // RULE4 RULE5

  function automatic logic [SAMPLE_BITS-1:0] encode(input logic [SAMPLE_BITS-1:0] s, input logic tc);
    encode = tc ? (s ^ SAMPLE_BITS'(MSB_MASK)) : s; // RULE1
  endfunction : encode

  always_comb begin
    pipe_nxt = pipe_r;
    pv_nxt   = pv_r;
    if (run) begin
      pipe_nxt[0] = {raw_over, raw_sample}; // RULE6 RULE9
      pv_nxt[0]   = 1'b1;
      for (int i = 1; i < LATENCY; i++) begin
        pipe_nxt[i] = pipe_r[i-1]; // RULE7
        pv_nxt[i]   = pv_r[i-1];
      end
    end else if (standard_powerdown) begin
      pv_nxt = '0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < LATENCY; i++) pipe_r[i] <= '0;
      pv_r <= '0;
    end else begin
      pipe_r <= pipe_nxt;
      pv_r   <= pv_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer; a short receiver stall loses no word. the converter cannot
  // be throttled, so a word that arrives while both entries wait is dropped
  logic [SAMPLE_BITS:0] buf_r [2];
  logic [SAMPLE_BITS:0] buf_nxt [2];
  logic [1:0]           cnt_r, cnt_nxt;
  logic                 in_v, pop;
  logic [SAMPLE_BITS:0] in_w;

  assign in_v = run && pv_r[LATENCY-1];
  assign in_w = pipe_r[LATENCY-1];
  assign pop  = sample_valid && sink_ready && !output_enable_n;

  always_comb begin
    buf_nxt = buf_r;
    cnt_nxt = cnt_r;
    if (pop) begin
      buf_nxt[0] = buf_r[1];
      cnt_nxt    = cnt_r - 2'h1;
    end
    if (in_v && (cnt_nxt != 2'h2)) begin
      buf_nxt[cnt_nxt[0]] = in_w;
      cnt_nxt             = cnt_nxt + 2'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      cnt_r    <= 2'h0;
    end else begin
      buf_r <= buf_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output word register and pin drive
  // the register loads the next buffer head, so it always mirrors buf_r[0];
  // coding is applied on load, so a coding change reaches the pins one clock later
  logic [SAMPLE_BITS-1:0] word_r, word_nxt;
  logic                   flag_r, flag_nxt;

  always_comb begin
    word_nxt = encode(buf_nxt[0][SAMPLE_BITS-1:0], coding_select); // RULE1
    flag_nxt = buf_nxt[0][SAMPLE_BITS]; // RULE9
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      word_r <= SAMPLE_RST;
      flag_r <= 1'b0;
    end else begin
      word_r <= word_nxt;
      flag_r <= flag_nxt;
    end
  end

  // data pins come straight from flip-flops; valid is a handshake and may be combinational
  assign sample_out      = word_r; // RULE6
  assign over_range_flag = flag_r; // RULE9
  assign sample_valid    = (cnt_r != 2'h0);
  assign sample_oe       = {SAMPLE_BITS{!output_enable_n}}; // RULE2
  assign over_range_oe   = !output_enable_n; // RULE2

  // stabilizer retimes 35..65 percent duty to 50; the digital side only flags it
  assign duty_cycle_stabilizer = duty_select; // RULE3 RULE8
  assign active                = run;
  assign quasi_down            = quasi_powerdown && !standard_powerdown; // RULE5

  ////////////////////////////////////////////////////////////////////////////
  // checks on the latency pipe

  // five pipe stages: five running edges give a valid tail, the buffer load comes one edge later
  latency_a: assert property (@(posedge mclk) disable iff (rst) // RULE7
    (run [*6]) |-> pv_r[LATENCY-1]) else $error("word not out after five clocks");

  pipe_a: assert property (@(posedge mclk) disable iff (rst) // RULE6
    run |=> pipe_r[0] == $past({raw_over, raw_sample})) else $error("sample not taken");

  powerdown_a: assert property (@(posedge mclk) disable iff (rst) // RULE4
    standard_powerdown |=> pv_r == '0) else $error("pipe alive in powerdown");

  down_a: assert property (@(posedge mclk) disable iff (rst) // RULE4
    standard_powerdown |-> !active) else $error("active in standard powerdown");

  quasi_a: assert property (@(posedge mclk) disable iff (rst) // RULE5
    quasi_powerdown |-> !active) else $error("active in quasi powerdown");

  // quasi powerdown keeps the pipe contents for a fast restart
  quasi_hold_a: assert property (@(posedge mclk) disable iff (rst) // RULE5
    quasi_powerdown && !standard_powerdown |=> $stable(pv_r) && $stable(pipe_r[LATENCY-1]))
    else $error("pipe moved in quasi powerdown");

  ////////////////////////////////////////////////////////////////////////////
  // checks on coding and pins

  // the word register holds reset contents for the first edge after release
  coding_a: assert property (@(posedge mclk) disable iff (rst) // RULE1
    !$past(rst) |-> sample_out[SAMPLE_BITS-1] == (buf_r[0][SAMPLE_BITS-1] ^ $past(coding_select)))
    else $error("bad coding");

  oe_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
    sample_oe[0] != output_enable_n) else $error("bad drive");

  flag_oe_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
    over_range_oe != output_enable_n) else $error("bad flag drive");

  dcs_a: assert property (@(posedge mclk) disable iff (rst) // RULE3
    duty_cycle_stabilizer == duty_select) else $error("stabilizer mismatch");

  flag_a: assert property (@(posedge mclk) disable iff (rst) // RULE9
    over_range_flag == buf_r[0][SAMPLE_BITS]) else $error("flag detached");

  ////////////////////////////////////////////////////////////////////////////
  // checks on the buffer

  cnt_a: assert property (@(posedge mclk) disable iff (rst)
    cnt_r <= 2'h2) else $error("buffer count overflow");

  // a waiting word stands until it is taken
  hold_a: assert property (@(posedge mclk) disable iff (rst)
    sample_valid && !pop |=> sample_valid && $stable(buf_r[0])) else $error("word lost");

  head_a: assert property (@(posedge mclk) disable iff (rst)
    pop && (cnt_r == 2'h2) |=> buf_r[0] == $past(buf_r[1])) else $error("second word lost");

  full_a: assert property (@(posedge mclk) disable iff (rst)
    (cnt_r == 2'h2) && !pop |=> cnt_r == 2'h2) else $error("full buffer drained");

  fill_a: assert property (@(posedge mclk) disable iff (rst)
    in_v && !sample_valid |=> sample_valid) else $error("word not buffered");

  empty_a: assert property (@(posedge mclk) disable iff (rst)
    !in_v && !sample_valid |=> !sample_valid) else $error("valid without word");

  ////////////////////////////////////////////////////////////////////////////
  // main scenarios reached
  stall_c: cover property (@(posedge mclk) cnt_r == 2'h2);
  stream_c: cover property (@(posedge mclk) pop [*4]);
  quasi_c: cover property (@(posedge mclk) quasi_powerdown ##1 !quasi_powerdown);
  drop_c: cover property (@(posedge mclk) (cnt_r == 2'h2) && in_v && !pop);
  coding_c: cover property (@(posedge mclk) sample_valid && coding_select);
endmodule : conv_out

// ==== test/capt_sink.sv ====
// capture side model: takes words off the output pins, can stall
// assumes one mclk domain and the output stage pins
`timescale 1ns/1ps
module capt_sink (
  input  wire logic        mclk,
  input  wire logic        stall,
  input  wire logic        output_enable_n,
  input  wire logic        sample_valid,
  input  wire logic [11:0] sample_out,
  output logic             sink_ready
);
  logic [11:0] got[$];
  assign sink_ready = !stall;
  // a word is taken only while the pins are driven
  always @(posedge mclk)
    if (sample_valid && sink_ready && !output_enable_n)
      got.push_back(sample_out);
endmodule : capt_sink

// ==== test/conv_out_tb.sv ====
// self-checking bench for the converter output stage
// assumes conv_out, capt_sink and a 40 MHz mclk
`timescale 1ns/1ps
module conv_out_tb;
  import conv_out_pkg::*;
  logic [11:0] raw_sample = 12'h000, sample_out, sample_oe;
  logic        mclk = 0, rst = 1, raw_over = 0, coding_select = 0, output_enable_n = 0, stall = 0;
  logic        duty_select = 0, standard_powerdown = 0, quasi_powerdown = 0, sink_ready, over_range_flag;
  logic        over_range_oe, sample_valid, duty_cycle_stabilizer, active, quasi_down;
  int          bad_count = 0, samples_checked = 0;
  always #12.5 mclk = ~mclk;
  // a counting ramp; over range follows bit 0
  always @(negedge mclk) begin
    raw_sample <= raw_sample + 12'h001;
    raw_over   <= !raw_sample[0];
  end
  conv_out i_conv_out (.mclk, .rst, .raw_sample, .raw_over, .coding_select, .output_enable_n, .duty_select,
    .standard_powerdown, .quasi_powerdown, .sink_ready, .sample_out, .sample_oe, .over_range_flag,
    .over_range_oe, .sample_valid, .duty_cycle_stabilizer, .active, .quasi_down);
  capt_sink i_capt_sink (.mclk, .stall, .output_enable_n, .sample_valid, .sample_out, .sink_ready);
  ////////////////////////////////////////////////////////////////
  task automatic check(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic tally_and_finish;
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic do_reset;
    rst = 1;
    repeat (10) @(negedge mclk);
    rst = 0;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////
  task automatic first_word;
    int n = 0;
    do_reset();
    while (sample_valid !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    check(n == LATENCY_CYC + 1, "first word");
    if (n == 20) tally_and_finish();
  endtask : first_word
  task automatic stream(input logic cs);
    logic [11:0] w;
    @(negedge mclk);
    coding_select = cs;
    repeat (8) @(negedge mclk);
    repeat (16) begin
      @(negedge mclk);
      w = raw_sample - 12'(LATENCY_CYC);
      check(sample_valid === 1'b1 && sample_out === (cs ? w ^ MSB_MASK : w), "word");
      check(over_range_flag === w[0], "over range");
    end
  endtask : stream
  task automatic modes;
    for (int i = 0; i < 6; i++) begin
      {quasi_powerdown, standard_powerdown, duty_select} = 3'(i);
      @(negedge mclk);
      check(duty_cycle_stabilizer === duty_select, "stabilizer");
      check(active === !(standard_powerdown | quasi_powerdown), "active");
      check(quasi_down === quasi_powerdown, "quasi");
    end
    {quasi_powerdown, standard_powerdown, duty_select} = 3'h0;
  endtask : modes
  task automatic tristate;
    int n0 = i_capt_sink.got.size();
    output_enable_n = 1;
    repeat (3) @(negedge mclk);
    check(sample_oe === 12'h000 && over_range_oe === 1'b0 && i_capt_sink.got.size() == n0, "float");
    output_enable_n = 0;
    @(negedge mclk);
    check(sample_oe === 12'hFFF && over_range_oe === 1'b1, "drive");
  endtask : tristate
  // a stalled receiver keeps the two oldest words, later ones are dropped
  task automatic stall_drop;
    int n = 0;
    do_reset();
    stall = 1;
    repeat (12) @(negedge mclk);
    i_capt_sink.got.delete();
    stall = 0;
    while (i_capt_sink.got.size() < 3 && n < 10) begin
      @(negedge mclk);
      n++;
    end
    check(n < 10, "no drain");
    if (n == 10) tally_and_finish();
    check(i_capt_sink.got[1] === i_capt_sink.got[0] + 12'h001 && i_capt_sink.got[2] !== i_capt_sink.got[0] + 12'h002, "buffer");
  endtask : stall_drop
  initial begin
    first_word();
    stream(1'b0);
    stream(1'b1);
    modes();
    tristate();
    stall_drop();
    tally_and_finish();
  end
endmodule : conv_out_tb
